// >>> design/pmgp_pkg.sv
// shared constants for the general purpose pin controller
package pmgp_pkg;

    // ==========================================================
    // pin organisation
    localparam int unsigned PMGP_PINS = 16;
    // bits 7:0 form low_voltage_pin_group (1.8 V supply),
    // bits 15:8 form high_voltage_pin_group (3.3 V supply)
    localparam int unsigned PMGP_GROUP_PINS = 8;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] PMGP_OFF_DIR = 8'h00;
    localparam logic [7:0] PMGP_OFF_PULL_EN = 8'h04;
    localparam logic [7:0] PMGP_OFF_PULL_DIR = 8'h08;
    localparam logic [7:0] PMGP_OFF_PULL_WEAK = 8'h0c;
    localparam logic [7:0] PMGP_OFF_OUT_LVL = 8'h10;
    localparam logic [7:0] PMGP_OFF_POLARITY = 8'h14;
    localparam logic [7:0] PMGP_OFF_DB_BYPASS = 8'h18;
    localparam logic [7:0] PMGP_OFF_IN_LVL = 8'h1c;
    localparam logic [7:0] PMGP_OFF_PAD_RB = 8'h20;
    localparam logic [7:0] PMGP_OFF_IRQ_STAT = 8'h24;
    localparam logic [7:0] PMGP_OFF_IRQ_MASK = 8'h28;

    // ==========================================================
    // reset values
    localparam logic [31:0] PMGP_RST_DIR = 32'h5555_5555;
    localparam logic [15:0] PMGP_RST_PULL_EN = 16'hffff;
    localparam logic [15:0] PMGP_RST_PULL_DIR = 16'h0000;
    localparam logic [15:0] PMGP_RST_PULL_WEAK = 16'hffff;
    localparam logic [15:0] PMGP_RST_OUT_LVL = 16'h0000;
    localparam logic [15:0] PMGP_RST_POLARITY = 16'h0000;
    localparam logic [15:0] PMGP_RST_DB_BYPASS = 16'h0000;
    localparam logic [15:0] PMGP_RST_IRQ_MASK = 16'hffff;

    // ==========================================================
    // pad mode codes, two bits per pin
    localparam logic [1:0] PMGP_MODE_ANALOG = 2'h0;
    localparam logic [1:0] PMGP_MODE_DIG_IN = 2'h1;
    localparam logic [1:0] PMGP_MODE_OPEN_DRAIN = 2'h2;
    localparam logic [1:0] PMGP_MODE_PUSH_PULL = 2'h3;

    // ==========================================================
    // bus answers
    localparam logic [1:0] PMGP_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMGP_RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing
    localparam int unsigned PMGP_CLK_NS = 25;
    localparam int unsigned PMGP_GLITCH_NS = 62_000;
    localparam int unsigned PMGP_GLITCH_CYC =
        (PMGP_GLITCH_NS + PMGP_CLK_NS - 1) / PMGP_CLK_NS;
    localparam int unsigned PMGP_DEBOUNCE_MS = 32;
    localparam int unsigned PMGP_DEBOUNCE_CYC =
        (PMGP_DEBOUNCE_MS * 1_000_000 + PMGP_CLK_NS - 1) / PMGP_CLK_NS;

endpackage : pmgp_pkg

// >>> design/pmgp_pin_filter.sv
// glitch filter followed by a bypassable debouncer for one pin
module pmgp_pin_filter
    import pmgp_pkg::*;
#(
    parameter int unsigned GLITCH_CYCLES = PMGP_GLITCH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = PMGP_DEBOUNCE_CYC
) (
    // clock and control
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // data
    input wire logic raw_i,
    input wire logic bypass_i,
    output logic filt_o
);

    localparam int unsigned GW = $clog2(GLITCH_CYCLES + 1);
    localparam int unsigned DW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [GW-1:0] G_LAST = GW'(GLITCH_CYCLES - 1);
    localparam logic [DW-1:0] D_LAST = DW'(DEBOUNCE_CYCLES - 1);

    if (GLITCH_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin : g_bad
        $error("filter lengths must be at least one cycle");
    end

    typedef struct packed {
        logic g_val;
        logic [GW-1:0] g_cnt;
        logic d_val;
        logic [DW-1:0] d_cnt;
        logic out;
    } pmgp_filt_t;

    pmgp_filt_t q;
    pmgp_filt_t next_q;

    // ==========================================================
    // a level is accepted only after it has stood unbroken for the
    // whole window; any return to the old level restarts the count
    always_comb begin
        next_q = q;
        if (raw_i == q.g_val) begin
            next_q.g_cnt = '0;
        end else if (q.g_cnt == G_LAST) begin
            next_q.g_val = raw_i;
            next_q.g_cnt = '0;
        end else begin
            next_q.g_cnt = q.g_cnt + 1'b1;
        end
        if (q.g_val == q.d_val) begin
            next_q.d_cnt = '0;
        end else if (q.d_cnt == D_LAST) begin
            next_q.d_val = q.g_val;
            next_q.d_cnt = '0;
        end else begin
            next_q.d_cnt = q.d_cnt + 1'b1;
        end
        next_q.out = bypass_i ? q.g_val : q.d_val;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign filt_o = q.out;

endmodule : pmgp_pin_filter

// >>> design/pmgp_port.sv
// sixteen general purpose pins with AXI4-Lite register access
//
// How it works
// [R1] sixteen pins, bits 7:0 at 1.8 V and bits 15:8 at 3.3 V
// [R2] reset leaves every pin a digital input with weak pull-down
// [R3] two mode bits per pin: analog, input, open-drain, push-pull
// [R4] pull enable, direction and strength bits choose the resistor
// [R5] five pad controls per pin; pad enable comes from the pad
// [R6] software reads back the level present on each pad
// [R7] an output pin drives the level software wrote for it
// [R8] glitch filter swallows input pulses shorter than 62 us
// [R9] a 32 ms debouncer follows, skipped per pin when bypassed
// [R10] per pin polarity may invert the input, active high at reset
// [R11] each pin may interrupt unless its mask bit is set
// [R12] flag sets on a change to the active level, held until cleared
// [R13] open-drain pulls low for a low level, floats for a high one
module pmgp_port
    import pmgp_pkg::*;
#(
    parameter int unsigned GLITCH_CYCLES = PMGP_GLITCH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = PMGP_DEBOUNCE_CYC
) (
    // clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    // write address channel
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic [2:0] S_AXI_AWPROT_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    // write data channel
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // write response channel
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // read address channel
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic [2:0] S_AXI_ARPROT_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    // read data channel
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // pad side, one bit per pin
    input wire logic [15:0] PAD_I,
    output logic [15:0] PAD_OUT_O,
    output logic [15:0] PAD_OE_O,
    output logic [15:0] PAD_PULL_EN_O,
    output logic [15:0] PAD_PULL_DIR_O,
    output logic [15:0] PAD_PULL_WEAK_O,
    // interrupt
    output logic IRQ_O
);

    if (PMGP_PINS != 2 * PMGP_GROUP_PINS || PMGP_PINS != 16) begin : g_bad
        $error("port is built for two groups of eight pins");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [31:0] dir;
        logic [15:0] pull_en;
        logic [15:0] pull_dir;
        logic [15:0] pull_weak;
        logic [15:0] out_lvl;
        logic [15:0] pol;
        logic [15:0] db_bypass;
        logic [15:0] mask;
        logic [15:0] stat;
        logic [15:0] act_prev;
        logic [15:0] pad_out;
        logic [15:0] pad_oe;
        logic irq;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pmgp_state_t;

    pmgp_state_t q;
    pmgp_state_t next_q;
    logic [15:0] filt;
    logic [15:0] raw_in;
    logic [15:0] act;

    // ==========================================================
    // helpers
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic addr_ok(input logic [7:0] a);
        logic [7:0] w;
        w = a & 8'hfc;
        addr_ok = (w <= PMGP_OFF_IRQ_MASK);
    endfunction : addr_ok

    function automatic logic [31:0] reg_read(
        input pmgp_state_t s,
        input logic [7:0] a,
        input logic [15:0] in_lvl
    );
        logic [7:0] w;
        w = a & 8'hfc;
        reg_read = 32'h0;
        case (w)
            PMGP_OFF_DIR: reg_read = s.dir;
            PMGP_OFF_PULL_EN: reg_read[15:0] = s.pull_en;
            PMGP_OFF_PULL_DIR: reg_read[15:0] = s.pull_dir;
            PMGP_OFF_PULL_WEAK: reg_read[15:0] = s.pull_weak;
            PMGP_OFF_OUT_LVL: reg_read[15:0] = s.out_lvl;
            PMGP_OFF_POLARITY: reg_read[15:0] = s.pol;
            PMGP_OFF_DB_BYPASS: reg_read[15:0] = s.db_bypass;
            PMGP_OFF_IN_LVL: reg_read[15:0] = in_lvl;
            PMGP_OFF_PAD_RB: reg_read[15:0] = s.sync2;
            PMGP_OFF_IRQ_STAT: reg_read[15:0] = s.stat;
            PMGP_OFF_IRQ_MASK: reg_read[15:0] = s.mask;
            default: reg_read = 32'h0;
        endcase
    endfunction : reg_read

    // ==========================================================
    // input path per pin
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // an analog pin has its digital receiver parked low
            raw_in[i] = q.sync2[i] & (q.dir[2*i +: 2] != PMGP_MODE_ANALOG);
        end
    end

    for (genvar g = 0; g < 16; g++) begin : g_pin
        pmgp_pin_filter #(
            .GLITCH_CYCLES(GLITCH_CYCLES),
            .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
        ) u_filt (
            .clk_i(SYS_CLK_I),
            .srst_i(SRST_I),
            .ce_i(CE_I),
            .raw_i(raw_in[g]),
            .bypass_i(q.db_bypass[g]),
            .filt_o(filt[g])
        ); // see [R8] see [R9]
    end

    assign act = filt ^ q.pol; // see [R10]

    // ==========================================================
    // bus handshakes, all frozen while the clock enable is low
    assign S_AXI_AWREADY_O = CE_I & ~q.aw_hold;
    assign S_AXI_WREADY_O = CE_I & ~q.w_hold;
    assign S_AXI_ARREADY_O = CE_I & ~q.rvalid;
    assign S_AXI_BVALID_O = q.bvalid;
    assign S_AXI_BRESP_O = q.bresp;
    assign S_AXI_RVALID_O = q.rvalid;
    assign S_AXI_RDATA_O = q.rdata;
    assign S_AXI_RRESP_O = q.rresp;

    // ==========================================================
    // next state
    always_comb begin
        logic do_write;
        logic [31:0] m;
        logic [31:0] merged;
        logic [15:0] rise;
        logic [15:0] clr;
        logic [1:0] md;
        next_q = q;
        do_write = 1'b0;
        m = 32'h0;
        merged = 32'h0;
        clr = 16'h0;
        rise = 16'h0;
        md = 2'h0;

        // pad samples cross two flops before use
        next_q.sync1 = PAD_I;
        next_q.sync2 = q.sync1; // see [R6]

        // write channels may arrive in either order
        if (S_AXI_AWVALID_I && !q.aw_hold) begin
            next_q.aw_hold = 1'b1;
            next_q.aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !q.w_hold) begin
            next_q.w_hold = 1'b1;
            next_q.w_data = S_AXI_WDATA_I;
            next_q.w_strb = S_AXI_WSTRB_I;
        end
        if (q.bvalid && S_AXI_BREADY_I) begin
            next_q.bvalid = 1'b0;
        end

        if (q.aw_hold && q.w_hold && !q.bvalid) begin
            do_write = addr_ok(q.aw_addr);
            next_q.aw_hold = 1'b0;
            next_q.w_hold = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = do_write ? PMGP_RESP_OKAY : PMGP_RESP_SLVERR;
        end

        m = strb_mask(q.w_strb);
        merged = (reg_read(q, q.aw_addr, act) & ~m) | (q.w_data & m);
        if (do_write) begin
            case (q.aw_addr & 8'hfc)
                PMGP_OFF_DIR: next_q.dir = merged; // see [R3]
                PMGP_OFF_PULL_EN: next_q.pull_en = merged[15:0];
                PMGP_OFF_PULL_DIR: next_q.pull_dir = merged[15:0];
                PMGP_OFF_PULL_WEAK: next_q.pull_weak = merged[15:0];
                PMGP_OFF_OUT_LVL: next_q.out_lvl = merged[15:0];
                PMGP_OFF_POLARITY: next_q.pol = merged[15:0];
                PMGP_OFF_DB_BYPASS: next_q.db_bypass = merged[15:0];
                PMGP_OFF_IRQ_MASK: next_q.mask = merged[15:0];
                PMGP_OFF_IRQ_STAT: clr = q.w_data[15:0] & m[15:0];
                default: clr = 16'h0;
            endcase
        end

        // a fresh edge beats a simultaneous write-one-to-clear
        rise = act & ~q.act_prev;
        next_q.act_prev = act;
        next_q.stat = (q.stat & ~clr) | rise; // see [R12]
        // masked flags stay visible but cannot reach the line
        next_q.irq = |(next_q.stat & ~next_q.mask); // see [R11]

        // reads answer one cycle after the address is taken
        if (q.rvalid && S_AXI_RREADY_I) begin
            next_q.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_I && !q.rvalid) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = reg_read(q, S_AXI_ARADDR_I, act);
            next_q.rresp = addr_ok(S_AXI_ARADDR_I) ? PMGP_RESP_OKAY
                                                  : PMGP_RESP_SLVERR;
        end

        // pad drive from the new configuration
        for (int i = 0; i < 16; i++) begin
            md = next_q.dir[2*i +: 2];
            unique case (md)
                PMGP_MODE_PUSH_PULL: begin
                    next_q.pad_out[i] = next_q.out_lvl[i]; // see [R7]
                    next_q.pad_oe[i] = 1'b1;
                end
                PMGP_MODE_OPEN_DRAIN: begin
                    next_q.pad_out[i] = 1'b0;
                    next_q.pad_oe[i] = ~next_q.out_lvl[i]; // see [R13]
                end
                PMGP_MODE_ANALOG, PMGP_MODE_DIG_IN: begin
                    next_q.pad_out[i] = 1'b0;
                    next_q.pad_oe[i] = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            q <= '0;
            q.dir <= PMGP_RST_DIR; // see [R2]
            q.pull_en <= PMGP_RST_PULL_EN;
            q.pull_dir <= PMGP_RST_PULL_DIR;
            q.pull_weak <= PMGP_RST_PULL_WEAK;
            q.out_lvl <= PMGP_RST_OUT_LVL;
            q.pol <= PMGP_RST_POLARITY; // see [R10]
            q.db_bypass <= PMGP_RST_DB_BYPASS;
            q.mask <= PMGP_RST_IRQ_MASK;
        end else if (CE_I) begin
            q <= next_q;
        end
    end

    // ==========================================================
    // pad outputs; pad enable itself is made inside the pad cell
    assign PAD_OUT_O = q.pad_out; // see [R5] see [R1]
    assign PAD_OE_O = q.pad_oe;
    assign PAD_PULL_EN_O = q.pull_en; // see [R4]
    assign PAD_PULL_DIR_O = q.pull_dir;
    assign PAD_PULL_WEAK_O = q.pull_weak;
    assign IRQ_O = q.irq;

endmodule : pmgp_port

// >>> sim/pmgp_port_sva.sv
// concurrent checks on the pin controller ports
module pmgp_port_sva
    import pmgp_pkg::*;
#(
    parameter int unsigned GLITCH_CYCLES = PMGP_GLITCH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = PMGP_DEBOUNCE_CYC
) (
    // clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    // bus
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // pads and interrupt
    input wire logic [15:0] PAD_OUT_O,
    input wire logic [15:0] PAD_OE_O,
    input wire logic [15:0] PAD_PULL_EN_O,
    input wire logic [15:0] PAD_PULL_DIR_O,
    input wire logic [15:0] PAD_PULL_WEAK_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // properties
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    a_reset_pads: assert property ($fell(SRST_I) |->
        PAD_OE_O == 16'h0 && PAD_OUT_O == 16'h0 && PAD_PULL_EN_O == 16'hffff
        && !IRQ_O && PAD_PULL_DIR_O == 16'h0 && PAD_PULL_WEAK_O == 16'hffff)
        else $error("pads not at reset setting");
    a_od_release: assert property (
        (PAD_OUT_O & ~PAD_OE_O) == 16'h0)
        else $error("high level without drive");
    a_pad_on_write: assert property ($changed(PAD_OE_O) ||
        $changed(PAD_OUT_O) || $changed(PAD_PULL_EN_O)
        |-> $rose(S_AXI_BVALID_O)) else $error("pad change without write");
    // flags only clear by a write, which answers at the same edge
    a_irq_sticky: assert property ($fell(IRQ_O) |->
        $rose(S_AXI_BVALID_O))
        else $error("interrupt dropped without write");
    a_b_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
        S_AXI_WVALID_I && S_AXI_WREADY_O && CE_I |-> ##[1:2] S_AXI_BVALID_O)
        else $error("write answer late");
    a_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O) else $error("write answer withdrawn");
    a_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> S_AXI_RVALID_O) else $error("read answer late");
    a_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read answer withdrawn");
    a_ar_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken while answer open");
    a_unmapped_rd: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
        S_AXI_ARADDR_I[7:2] > 6'h0a |=> S_AXI_RRESP_O == PMGP_RESP_SLVERR
        && S_AXI_RDATA_O == 32'h0) else $error("unmapped read accepted");
    a_ce_ready: assert property (!CE_I |-> !(S_AXI_AWREADY_O ||
        S_AXI_WREADY_O || S_AXI_ARREADY_O)) else $error("ready while frozen");

    c_irq_rise: cover property ($rose(IRQ_O));
    c_irq_fall: cover property ($fell(IRQ_O));
    c_slverr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O[1]);
endmodule : pmgp_port_sva

bind pmgp_port pmgp_port_sva #(
    .GLITCH_CYCLES(GLITCH_CYCLES),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) pmgp_port_sva_i (.*);

// >>> sim/pmgp_pin_dev.sv
// platform devices and pull resistors resolving the sixteen pad wires
module pmgp_pin_dev (
    // clock
    input wire logic clk_i,
    // pad controls from the port
    input wire logic [15:0] pad_out_i,
    input wire logic [15:0] pad_oe_i,
    input wire logic [15:0] pull_en_i,
    input wire logic [15:0] pull_dir_i,
    // devices, driven by the bench
    input wire logic [15:0] dev_oe_i,
    input wire logic [15:0] dev_lvl_i,
    // resolved wire level
    output logic [15:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0;

    // ==========================================================
    // wire resolution; a floating pin toggles so no stale level passes
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pad_oe_i[i])
                pad_o[i] = pad_out_i[i];
            else if (dev_oe_i[i])
                pad_o[i] = dev_lvl_i[i];
            else if (pull_en_i[i])
                pad_o[i] = pull_dir_i[i];
            else
                pad_o[i] = ~last[i];
        end
    end
    always_ff @(posedge clk_i) last <= pad_o;
endmodule : pmgp_pin_dev

// >>> sim/pmgp_port_tb.sv
// self-checking bench for the sixteen pin controller
module pmgp_port_tb;
    import pmgp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
        error_cnt++; $display("ERROR %s expected %h seen %h", nm, e, g); \
        end end

    // ==========================================================
    // signals
    localparam int unsigned GLITCH = 4;
    localparam int unsigned DEBOUNCE = 16;
    int error_cnt = 0, compares = 0;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [15:0] pad_in, pad_out, pad_oe, pull_en, pull_dir, pull_weak;
    logic [15:0] dev_oe = 16'h0, dev_lvl = 16'h0;
    logic [31:0] rst_tab [11] = '{32'h5555_5555, 32'hffff, 32'h0,
        32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffff};
    logic [15:0] oe_tab [4] = '{16'h0, 16'h0, 16'hff00, 16'hffff};
    logic [15:0] pull_tab [3] = '{16'hf0f0, 16'hff00, 16'h0f0f};

    initial forever #12.5 clk = ~clk;

    pmgp_port #(.GLITCH_CYCLES(GLITCH), .DEBOUNCE_CYCLES(DEBOUNCE))
    pmgp_port_i (.SYS_CLK_I(clk), .SRST_I(srst), .CE_I(ce),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .PAD_I(pad_in), .PAD_OUT_O(pad_out),
        .PAD_OE_O(pad_oe), .PAD_PULL_EN_O(pull_en),
        .PAD_PULL_DIR_O(pull_dir), .PAD_PULL_WEAK_O(pull_weak),
        .IRQ_O(irq));

    pmgp_pin_dev pmgp_pin_dev_i (.clk_i(clk), .pad_out_i(pad_out),
        .pad_oe_i(pad_oe), .pull_en_i(pull_en), .pull_dir_i(pull_dir),
        .dev_oe_i(dev_oe), .dev_lvl_i(dev_lvl), .pad_o(pad_in));

    // ==========================================================
    // tasks
    task automatic end_sim;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic give_up(input string what);
        error_cnt++;
        $display("ERROR %s expected answer seen none", what);
        end_sim();
    endtask : give_up

    // requests start right after an edge and are held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // bready stays high between calls so it is never set twice at once
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (++n > 50) give_up("write");
        end while (!bvalid);
        `CHK("write code", a > PMGP_OFF_IRQ_MASK ? PMGP_RESP_SLVERR
            : PMGP_RESP_OKAY, bresp)
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (++n > 50) give_up("read");
        end while (!rvalid);
        `CHK("read code", a > 8'h28 ? PMGP_RESP_SLVERR : PMGP_RESP_OKAY, rresp)
        `CHK($sformatf("register %h", a), e, rdata)
    endtask : rd_chk

    task automatic pulse(input int p, input int n);
        dev_oe[p] <= 1'b1;
        dev_lvl[p] <= 1'b1;
        repeat (n) @(posedge clk);
        dev_oe[p] <= 1'b0;
        dev_lvl[p] <= 1'b0;
        repeat (60) @(posedge clk);
    endtask : pulse

    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq !== e) begin
            @(posedge clk);
            if (++n > 300) give_up("interrupt");
        end
        compares++;
    endtask : wait_irq

    // ==========================================================
    // sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("pull enables", 16'hffff, pull_en)
        `CHK("pull directions", 16'h0, pull_dir)
        `CHK("pull strengths", 16'hffff, pull_weak)
        `CHK("drive enables", 16'h0, pad_oe)
        for (int i = 0; i < 11; i++)
            rd_chk(8'(4 * i), rst_tab[i]);
        rd_chk(8'h2c, 32'h0);
        wr(8'h2c, 32'hffff_ffff, 4'hf);
        rd_chk(PMGP_OFF_IRQ_MASK, 32'hffff);
        ce <= 1'b0;
        @(posedge clk);
        `CHK("readies", 3'h0, {awready, wready, arready})
        ce <= 1'b1;
        wr(PMGP_OFF_OUT_LVL, 32'h0000_00ff, 4'hf);
        for (int m = 0; m < 4; m++) begin
            wr(PMGP_OFF_DIR, {16{m[1:0]}}, 4'hf);
            @(posedge clk);
            `CHK("drive enables", oe_tab[m], pad_oe)
            `CHK("drive level", m == 3 ? 16'h00ff : 16'h0, pad_out)
        end
        repeat (4) @(posedge clk);
        rd_chk(PMGP_OFF_PAD_RB, 32'h0000_00ff);
        wr(PMGP_OFF_OUT_LVL, 32'hffff_ffff, 4'h2);
        wr(PMGP_OFF_PAD_RB, 32'h0, 4'hf);
        `CHK("byte lane", 16'hffff, pad_out)
        repeat (4) @(posedge clk);
        rd_chk(PMGP_OFF_PAD_RB, 32'hffff);
        for (int i = 0; i < 3; i++)
            wr(PMGP_OFF_PULL_EN + 8'(4 * i), {16'h0, pull_tab[i]}, 4'hf);
        `CHK("pull enables", pull_tab[0], pull_en)
        `CHK("pull directions", pull_tab[1], pull_dir)
        `CHK("pull strengths", pull_tab[2], pull_weak)
        wr(PMGP_OFF_PULL_EN, 32'hffff, 4'hf);
        wr(PMGP_OFF_PULL_DIR, 32'h0, 4'hf);
        wr(PMGP_OFF_DIR, 32'h5555_5555, 4'hf);
        wr(PMGP_OFF_DB_BYPASS, 32'h2, 4'hf);
        wr(PMGP_OFF_IRQ_MASK, 32'hfffe, 4'hf);
        repeat (60) @(posedge clk);
        wr(PMGP_OFF_IRQ_STAT, 32'hffff, 4'hf);
        rd_chk(PMGP_OFF_IRQ_STAT, 32'h0);
        pulse(1, 8);
        pulse(2, 8);
        rd_chk(PMGP_OFF_IRQ_STAT, 32'h2);
        `CHK("interrupt", 1'b0, irq)
        pulse(0, 2);
        rd_chk(PMGP_OFF_IRQ_STAT, 32'h2);
        dev_oe[0] <= 1'b1;
        dev_lvl[0] <= 1'b1;
        wait_irq(1'b1);
        rd_chk(PMGP_OFF_IN_LVL, 32'h1);
        rd_chk(PMGP_OFF_IRQ_STAT, 32'h3);
        wr(PMGP_OFF_IRQ_STAT, 32'h1, 4'hf);
        wait_irq(1'b0);
        repeat (60) @(posedge clk);
        rd_chk(PMGP_OFF_IRQ_STAT, 32'h2);
        wr(PMGP_OFF_POLARITY, 32'h1, 4'hf);
        repeat (60) @(posedge clk);
        rd_chk(PMGP_OFF_IN_LVL, 32'h0);
        dev_lvl[0] <= 1'b0;
        wait_irq(1'b1);
        wr(PMGP_OFF_IN_LVL, 32'h0, 4'hf);
        rd_chk(PMGP_OFF_IN_LVL, 32'h1);
        end_sim();
    end
endmodule : pmgp_port_tb
